// *** rtl/rom_loader_pkg.sv ***
// constants shared by the serial rom preloader and its bit engine
package rom_loader_pkg;
  localparam logic [7:0] ROM_DEV_ADDR = 8'hA0;
  localparam logic [7:0] ROM_RD_BIT = 8'h01;
  localparam logic [7:0] CARD_FLAG_WORD = 8'h20;
  localparam logic [7:0] CARD_FIRST_WORD = 8'h21;
  localparam logic [7:0] CARD_LAST_WORD = 8'h34;
  localparam logic [7:0] CARD_SKIP_FLAG = 8'hFF;
  localparam logic [7:0] HOST_FIRST_WORD = 8'h00;
  localparam logic [7:0] HOST_LAST_WORD = 8'h12;
  localparam logic [5:0] WINDOW_IDX = 6'h06;
  localparam logic [5:0] CARD_IDX_OFS = 6'h0E;
  localparam int unsigned IMG_BYTES = 39;
  localparam logic [7:0] IMG_RESET = 8'h00;
  // checksum and compatibility id bytes are read-only
  localparam logic [38:0] IMG_WRITABLE = 39'h3F_FFFF_7FFF;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0C;
  localparam logic [7:0] REG_ROM_PORT = 8'h10;
  localparam logic [7:0] REG_IMAGE_BASE = 8'h40;
  localparam logic [7:0] REG_IMAGE_END = 8'hD8;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_ERROR = 1;
  localparam int unsigned ST_PRESENT = 2;
  localparam int unsigned ST_CARD_DONE = 3;
  localparam int unsigned ST_HOST_DONE = 4;
  localparam int unsigned ST_PORT_BUSY = 5;
  localparam int unsigned IRQ_CARD = 0;
  localparam int unsigned IRQ_HOST = 1;
  localparam int unsigned IRQ_ERR = 2;
  localparam int unsigned IRQ_PORT = 3;
  localparam int unsigned CTL_PTR_RESET = 0;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SCL_QUARTER_NS = 2500;
  localparam int unsigned SCL_QUARTER_CYC =
    (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_STOP  = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ  = 3'h3,
    CMD_ACK   = 3'h4
  } cmd_e;
endpackage

// *** rtl/rom_bit_engine.sv ***
// two-wire bit engine: start, stop, byte write, byte read, ack bit
`timescale 1ns/1ns
module rom_bit_engine #(
  parameter int unsigned QUARTER_CYC = rom_loader_pkg::SCL_QUARTER_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sda_in,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            rx_nack,
  output logic            scl_oe,
  output logic            sda_oe
);
  logic       active_r;
  logic [2:0] cmd_r;
  logic [7:0] tmr_r;
  logic [1:0] qtr_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic       sda_low;

  wire tick     = active_r && (tmr_r == 8'(QUARTER_CYC - 1));
  wire is_write = cmd_r == rom_loader_pkg::CMD_WRITE;
  wire is_read  = cmd_r == rom_loader_pkg::CMD_READ;
  wire is_stop  = cmd_r == rom_loader_pkg::CMD_STOP;
  wire [3:0] last_bit = is_write ? 4'h8 : (is_read ? 4'h7 : 4'h0);
  wire bit_end  = tick && (qtr_r == 2'h3);
  wire sample   = tick && (qtr_r == 2'h2);
  wire scl_low  = (qtr_r == 2'h0) || ((qtr_r == 2'h3) && !is_stop);

  always_comb begin
    case (cmd_r)
      rom_loader_pkg::CMD_START: sda_low = qtr_r[1];
      rom_loader_pkg::CMD_STOP:  sda_low = !qtr_r[1];
      rom_loader_pkg::CMD_WRITE: sda_low = (bit_r != 4'h8) && !sh_r[7];
      rom_loader_pkg::CMD_ACK:   sda_low = !sh_r[7];
      default:                   sda_low = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce && active_r) begin
      scl_oe <= scl_low;
      sda_oe <= sda_low;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= 8'h00;
      rx_nack <= 1'b0;
    end else if (ce && sample) begin
      if (is_read)
        rx_byte <= {rx_byte[6:0], sda_in};
      if (is_write && (bit_r == 4'h8))
        rx_nack <= sda_in;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      done     <= 1'b0;
      cmd_r    <= 3'h0;
      tmr_r    <= 8'h00;
      qtr_r    <= 2'h0;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
    end else if (ce) begin
      done <= 1'b0;
      if (!active_r) begin
        if (cmd_valid) begin
          active_r <= 1'b1;
          cmd_r    <= cmd;
          tmr_r    <= 8'h00;
          qtr_r    <= 2'h0;
          bit_r    <= 4'h0;
          sh_r     <= tx_byte;
        end
      end else begin
        tmr_r <= tick ? 8'h00 : tmr_r + 8'h01;
        if (tick)
          qtr_r <= qtr_r + 2'h1;
        if (bit_end) begin
          if (bit_r == last_bit) begin
            active_r <= 1'b0;
            done     <= 1'b1;
          end else begin
            bit_r <= bit_r + 4'h1;
            sh_r  <= {sh_r[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule

// *** rtl/serial_rom_register_preloader.sv ***
// serial rom sequencer that preloads card and host register bytes
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - every rom access uses device byte A0
// - card loader busy gates host loader start
// - card load begins at word 0x20
// - only writable bits take rom data
// - flag byte at 32 gates words 33-52
// - flag FF stops card load only
// - host pass maps words 0 to 18
// - card pass maps words 33 to 52
// - word 6 gives rom window start
// - pointer reset returns to window start
// - auto load only with strap pulldown
// - error flag on nack, status busy while loading, loader_busy pin during card pass only
module serial_rom_register_preloader #(
  parameter int unsigned QUARTER_CYC = rom_loader_pkg::SCL_QUARTER_CYC
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic             loader_busy,
  input  wire logic        rom_strap_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             scl_oe
);
  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_START  = 4'b0001,
    S_DEVW   = 4'b0011,
    S_WADDR  = 4'b0010,
    S_RSTART = 4'b0110,
    S_DEVR   = 4'b0111,
    S_READ   = 4'b0101,
    S_ACK    = 4'b0100,
    S_STOP   = 4'b1100
  } seq_e;
  typedef enum logic [1:0] {
    PH_CARD = 2'b00,
    PH_HOST = 2'b01,
    PH_SW   = 2'b11
  } phase_e;

  logic        rst_q1_r, rst_n;
  logic        strap_q1_r, strap_q2_r, sda_q1_r, sda_q2_r;
  logic [1:0]  boot_cnt_r;
  logic        present_r, auto_pend_r, port_req_r;
  seq_e        state_r, state_nxt;
  phase_e      phase_r;
  logic        pend_r, abort_r, ack_bit_r;
  logic [7:0]  word_r, last_r, ptr_r, port_data_r;
  logic        error_r, card_done_r, host_done_r;
  logic [3:0]  irq_stat_r, irq_mask_r;
  logic [7:0]  img_r [rom_loader_pkg::IMG_BYTES];
  logic        eng_done, eng_nack;
  logic [7:0]  eng_rx;
  logic [2:0]  eng_cmd;
  logic [7:0]  eng_tx;

  // reset release and pin synchronisers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_q1_r <= 1'b1;
      strap_q2_r <= 1'b1;
      sda_q1_r   <= 1'b1;
      sda_q2_r   <= 1'b1;
    end else if (ce) begin
      strap_q1_r <= rom_strap_n;
      strap_q2_r <= strap_q1_r;
      sda_q1_r   <= sda_in;
      sda_q2_r   <= sda_q1_r;
    end
  end

  // strap caught once the synchroniser has filled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r  <= 2'h0;
      present_r   <= 1'b0;
      auto_pend_r <= 1'b0;
    end else if (ce) begin
      if (boot_cnt_r != 2'h3)
        boot_cnt_r <= boot_cnt_r + 2'h1;
      if (boot_cnt_r == 2'h2) begin
        present_r   <= !strap_q2_r;
        auto_pend_r <= !strap_q2_r;
      end else if (state_r == S_IDLE) begin
        auto_pend_r <= 1'b0;
      end
    end
  end

  // bus decode
  wire wr_ctl   = reg_wr && (reg_addr == rom_loader_pkg::REG_CONTROL);
  wire wr_mask  = reg_wr && (reg_addr == rom_loader_pkg::REG_IRQ_MASK);
  wire wr_port  = reg_wr && (reg_addr == rom_loader_pkg::REG_ROM_PORT);
  wire rd_istat = reg_rd && (reg_addr == rom_loader_pkg::REG_IRQ_STAT);
  wire in_img   = (reg_addr >= rom_loader_pkg::REG_IMAGE_BASE) &&
                  (reg_addr <= rom_loader_pkg::REG_IMAGE_END) &&
                  (reg_addr[1:0] == 2'b00);
  wire [7:0] img_ofs = reg_addr - rom_loader_pkg::REG_IMAGE_BASE;
  wire [5:0] bus_idx = img_ofs[7:2];
  wire ptr_reset = wr_ctl && reg_wdata[rom_loader_pkg::CTL_PTR_RESET];
  wire port_busy = port_req_r || (phase_r == PH_SW && state_r != S_IDLE);
  wire load_busy = (state_r != S_IDLE) && (phase_r != PH_SW);

  // sequencer control
  wire eng_go  = (state_r != S_IDLE) && !pend_r;
  wire step    = pend_r && eng_done;
  wire rd_done = step && (state_r == S_READ);
  wire is_flag = (phase_r == PH_CARD) &&
                 (word_r == rom_loader_pkg::CARD_FLAG_WORD);
  wire flag_ff = is_flag && (eng_rx == rom_loader_pkg::CARD_SKIP_FLAG);
  wire is_last = (word_r == last_r) || flag_ff;
  wire fin     = step && (state_r == S_STOP);
  wire [5:0] ld_idx = (phase_r == PH_CARD) ?
                      word_r[5:0] - rom_loader_pkg::CARD_IDX_OFS :
                      word_r[5:0];
  wire ld_img  = rd_done && !is_flag && (phase_r != PH_SW);

  always_comb begin
    case (state_r)
      S_START, S_RSTART: eng_cmd = rom_loader_pkg::CMD_START;
      S_DEVW, S_WADDR, S_DEVR: eng_cmd = rom_loader_pkg::CMD_WRITE;
      S_READ:  eng_cmd = rom_loader_pkg::CMD_READ;
      S_ACK:   eng_cmd = rom_loader_pkg::CMD_ACK;
      default: eng_cmd = rom_loader_pkg::CMD_STOP;
    endcase
  end

  always_comb begin
    case (state_r)
      S_DEVW:  eng_tx = rom_loader_pkg::ROM_DEV_ADDR;
      S_DEVR:  eng_tx = rom_loader_pkg::ROM_DEV_ADDR |
                        rom_loader_pkg::ROM_RD_BIT;
      S_WADDR: eng_tx = word_r;
      S_ACK:   eng_tx = {ack_bit_r, 7'h00};
      default: eng_tx = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (auto_pend_r || port_req_r)
          state_nxt = S_START;
      end
      S_START:  if (step) state_nxt = S_DEVW;
      S_DEVW:   if (step) state_nxt = eng_nack ? S_STOP : S_WADDR;
      S_WADDR:  if (step) state_nxt = eng_nack ? S_STOP : S_RSTART;
      S_RSTART: if (step) state_nxt = S_DEVR;
      S_DEVR:   if (step) state_nxt = eng_nack ? S_STOP : S_READ;
      S_READ:   if (step) state_nxt = S_ACK;
      S_ACK:    if (step) state_nxt = ack_bit_r ? S_STOP : S_READ;
      S_STOP: begin
        if (step)
          state_nxt = (phase_r == PH_CARD) ? S_START : S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      pend_r  <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (eng_go)
        pend_r <= 1'b1;
      else if (step)
        pend_r <= 1'b0;
    end
  end

  // pass setup, word walk and abort handling
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_r   <= PH_CARD;
      word_r    <= rom_loader_pkg::CARD_FLAG_WORD;
      last_r    <= rom_loader_pkg::CARD_LAST_WORD;
      ack_bit_r <= 1'b0;
      abort_r   <= 1'b0;
    end else if (ce) begin
      if (state_r == S_IDLE && !auto_pend_r && port_req_r) begin
        phase_r <= PH_SW;
        word_r  <= ptr_r;
        last_r  <= ptr_r;
        abort_r <= 1'b0;
      end else if (state_r == S_IDLE && auto_pend_r) begin
        phase_r <= PH_CARD;
        word_r  <= rom_loader_pkg::CARD_FLAG_WORD;
        last_r  <= rom_loader_pkg::CARD_LAST_WORD;
        abort_r <= 1'b0;
      end
      if (step && eng_nack &&
          (state_r == S_DEVW || state_r == S_WADDR || state_r == S_DEVR))
        abort_r <= 1'b1;
      if (rd_done) begin
        ack_bit_r <= is_last;
      end
      if (step && state_r == S_ACK && !ack_bit_r)
        word_r <= word_r + 8'h01;
      if (fin && phase_r == PH_CARD) begin
        phase_r <= PH_HOST;
        word_r  <= rom_loader_pkg::HOST_FIRST_WORD;
        last_r  <= rom_loader_pkg::HOST_LAST_WORD;
        abort_r <= 1'b0;
      end
    end
  end

  // status flags and software rom window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      error_r     <= 1'b0;
      card_done_r <= 1'b0;
      host_done_r <= 1'b0;
      loader_busy <= 1'b0;
    end else if (ce) begin
      if (step && eng_nack && state_r != S_READ && state_r != S_ACK &&
          eng_cmd == rom_loader_pkg::CMD_WRITE)
        error_r <= 1'b1;
      if (fin && phase_r == PH_CARD)
        card_done_r <= 1'b1;
      if (fin && phase_r == PH_HOST)
        host_done_r <= 1'b1;
      loader_busy <= auto_pend_r ||
                     (phase_r == PH_CARD && state_r != S_IDLE &&
                      !fin);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r       <= 8'h00;
      port_req_r  <= 1'b0;
      port_data_r <= 8'h00;
    end else if (ce) begin
      if (ptr_reset)
        ptr_r <= img_r[rom_loader_pkg::WINDOW_IDX];
      else if (fin && phase_r == PH_SW && !abort_r)
        ptr_r <= ptr_r + 8'h01;
      if (wr_port && !port_busy && host_done_r)
        port_req_r <= 1'b1;
      else if (state_r == S_IDLE && !auto_pend_r)
        port_req_r <= 1'b0;
      if (rd_done && phase_r == PH_SW)
        port_data_r <= eng_rx;
    end
  end

  // register image, one byte per entry
  for (genvar i = 0; i < rom_loader_pkg::IMG_BYTES; i++) begin : g_img
    localparam bit WRITABLE = rom_loader_pkg::IMG_WRITABLE[i];
    wire ld_hit = ld_img && (ld_idx == 6'(i));
    wire sw_hit = reg_wr && in_img && (bus_idx == 6'(i));
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
        img_r[i] <= rom_loader_pkg::IMG_RESET;
      else if (ce && WRITABLE && ld_hit)
        img_r[i] <= eng_rx;
      else if (ce && WRITABLE && sw_hit)
        img_r[i] <= reg_wdata[7:0];
    end
  end

  // interrupts: set wins over read clear
  wire [3:0] irq_ev = {
    fin && phase_r == PH_SW,
    step && eng_nack && eng_cmd == rom_loader_pkg::CMD_WRITE,
    fin && phase_r == PH_HOST,
    fin && phase_r == PH_CARD
  };
  wire [3:0] irq_nxt = (rd_istat ? 4'h0 : irq_stat_r) | irq_ev;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= rom_loader_pkg::IRQ_RESET;
      irq_mask_r <= rom_loader_pkg::IRQ_RESET;
      irq        <= 1'b0;
    end else if (ce) begin
      irq_stat_r <= irq_nxt;
      if (wr_mask)
        irq_mask_r <= reg_wdata[3:0];
      irq <= |(irq_nxt & irq_mask_r);
    end
  end

  // read data, present in the cycle after the strobe only
  wire [31:0] status_word = {26'h000_0000,
    port_busy, host_done_r, card_done_r, present_r, error_r,
    load_busy};
  wire [7:0] img_byte = img_r[bus_idx];
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      rom_loader_pkg::REG_STATUS:   rd_mux = status_word;
      rom_loader_pkg::REG_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_r};
      rom_loader_pkg::REG_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_r};
      rom_loader_pkg::REG_ROM_PORT:
        rd_mux = {23'h00_0000, port_busy, port_data_r};
      default: rd_mux = in_img ? {24'h00_0000, img_byte} : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
      sda_out   <= 1'b0;
      scl_out   <= 1'b0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      sda_out   <= 1'b0;
      scl_out   <= 1'b0;
    end
  end

  // stop leaves both lines released
  rom_bit_engine #(
    .QUARTER_CYC (QUARTER_CYC)
  ) u_engine (
    .clock     (clock),
    .rst_n     (rst_n),
    .ce        (ce),
    .cmd_valid (eng_go),
    .cmd       (eng_cmd),
    .tx_byte   (eng_tx),
    .sda_in    (sda_q2_r),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .rx_nack   (eng_nack),
    .scl_oe    (scl_oe),
    .sda_oe    (sda_oe)
  );
endmodule

// *** tb/rom_loader_props.sv ***
// port-level checks for the serial rom preloader
`timescale 1ns/1ns
module rom_loader_props #(
  parameter int unsigned QUARTER_CYC = 2
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq,
  input wire logic        loader_busy,
  input wire logic        rom_strap_n,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        scl_out,
  input wire logic        scl_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  logic [3:0] mask_r;
  logic [7:0] hi_r;
  // mirror of the mask; length of the current scl high run
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask_r <= 4'h0;
      hi_r   <= 8'hFF;
    end else begin
      if (ce && reg_wr && reg_addr == rom_loader_pkg::REG_IRQ_MASK)
        mask_r <= reg_wdata[3:0];
      hi_r <= scl_oe ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + 8'h01);
    end
  end
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
  property p_unmapped;
    $past(reg_rd && reg_addr == 8'hFC) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_busy_rd;
    $past(reg_rd && reg_addr == rom_loader_pkg::REG_STATUS && loader_busy)
      |-> reg_rdata[rom_loader_pkg::ST_BUSY];
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy bit low");
  property p_irq_mask;
    $past(mask_r) == 4'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_no_strap;
    rom_strap_n |-> !loader_busy && !scl_oe && !sda_oe;
  endproperty
  a_no_strap: assert property (p_no_strap) else $error("load w/o strap");
  property p_busy_start;
    $rose(loader_busy) |-> ##[0:40] scl_oe;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("idle bus");
  property p_busy_end;
    $fell(loader_busy) |-> !sda_oe && !scl_oe && !sda_out && !scl_out;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("sda held");
  property p_scl_high;
    $rose(scl_oe) |-> int'(hi_r) >= 2 * QUARTER_CYC;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high short");
endmodule

// *** tb/eeprom_model.sv ***
// behavioural two-wire serial rom at the fixed device address
`timescale 1ns/1ns
module eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack_dev,
  output logic      sda_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh = 8'h00;
  logic       ok = 1'b0;
  int         ph = 0;
  int         bc = 0;
  initial sda_oe = 1'b0;
  // start and stop conditions
  always @(negedge sda) begin
    if (scl) begin
      ph = 1;
      bc = -1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      ph = 0;
      sda_oe = 1'b0;
    end
  end
  always @(posedge scl) begin
    if ((ph == 1 || ph == 2) && bc >= 0 && bc < 8) sh = {sh[6:0], sda};
    if (ph == 3 && bc == 8) begin
      ptr = ptr + 8'h01;
      if (sda) ph = 0;
    end
  end
  // ph 1 device byte, 2 word address, 3 reading, 4 wait restart
  always @(negedge scl) begin
    if (ph != 0) begin
      bc = bc + 1;
      if (bc == 8 && ph < 3) ok = !nack_dev && (ph == 2 || sh[7:1] == 7'h50);
      if (bc == 9) begin
        bc = 0;
        if (ph < 3 && !ok) ph = 0;
        else if (ph == 1) ph = sh[0] ? 3 : 2;
        else if (ph == 2) begin
          ptr = sh;
          ph = 4;
        end
      end
      if (ph == 3 && bc < 8) sda_oe = !mem[ptr][3'(7 - bc)];
      else sda_oe = (bc == 8 && ph < 3) ? ok : 1'b0;
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the serial rom preloader
`timescale 1ns/1ns
module testbench;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rom_strap_n = 1'b1;
  logic        ce = 1'b1;
  logic        nack_dev = 1'b0;
  logic        rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq, loader_busy, sda_out, sda_oe, scl_out, scl_oe, m_oe;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          err_total = 0;
  int          n_tests = 0;
  wire         sda = !(sda_oe || m_oe);
  wire         scl = !scl_oe;
  serial_rom_register_preloader #(.QUARTER_CYC(2))
    i_serial_rom_register_preloader (
    .clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .loader_busy(loader_busy),
    .rom_strap_n(rom_strap_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
  eeprom_model i_eeprom_model (
    .scl(scl), .sda(sda), .nack_dev(nack_dev), .sda_oe(m_oe));
  always #50 clock = ~clock;
  always @(posedge clock) rd_d <= reg_rd;
  always @(negedge clock) begin
    if (rd_d && exp_q.size() > 0) begin
      chk(reg_rdata & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] rom(input logic [7:0] a);
    return i_eeprom_model.mem[a];
  endfunction
  function automatic logic [7:0] ia(input int i);
    return 8'(rom_loader_pkg::REG_IMAGE_BASE + 4 * i);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int k;
    for (k = 0; k < 400; k++) begin
      reg_addr <= rom_loader_pkg::REG_STATUS;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      if ((reg_rdata & m) === v) break;
      repeat (20) @(posedge clock);
    end
    if (k == 400) chk(32'h0000_0000, 32'h0000_0001);
    @(posedge clock);
  endtask
  task automatic wait_lb(input logic v);
    int k;
    for (k = 0; k < 20000; k++) begin
      if (loader_busy === v) break;
      @(posedge clock);
    end
    if (k == 20000) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic chk_irq(input logic v);
    @(negedge clock);
    chk({31'h0000_0000, irq}, {31'h0000_0000, v});
    @(posedge clock);
  endtask
  task automatic do_reset(input logic strap_n, input logic nk);
    rstn <= 1'b0;
    rom_strap_n <= strap_n;
    nack_dev <= nk;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic chk_img(input bit card);
    logic [7:0] e;
    for (int i = 0; i < 39; i++) begin
      e = i < 19 ? rom(8'(i)) : (card ? rom(8'(i + 14)) : 8'h00);
      if (!rom_loader_pkg::IMG_WRITABLE[i]) e = 8'h00;
      rd(ia(i), {24'h00_0000, e});
    end
  endtask
  task automatic port_rd(input logic [7:0] a);
    wr(rom_loader_pkg::REG_ROM_PORT, 32'h0000_0000);
    wait_st(32'h0000_0020, 32'h0000_0000);
    rd(rom_loader_pkg::REG_ROM_PORT, {24'h00_0000, rom(a)});
  endtask
  initial begin
    #6_000_000;
    err_total++;
    test_done();
  end
  initial begin
    logic [7:0] w;
    void'($urandom(32'h3023a25f));
    for (int i = 0; i < 256; i++) i_eeprom_model.mem[i] = 8'($urandom);
    i_eeprom_model.mem[32] = rom(8'h20) & 8'h7F;
    do_reset(1'b1, 1'b0);
    repeat (40) @(posedge clock);
    rd(rom_loader_pkg::REG_STATUS, 32'h0000_0000);
    rd(rom_loader_pkg::REG_IRQ_MASK, 32'h0000_0000);
    rd(ia(0), 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    rd(8'hDC, 32'h0000_0000);
    do_reset(1'b0, 1'b0);
    wr(rom_loader_pkg::REG_IRQ_MASK, 32'h0000_0003);
    wait_lb(1'b1);
    rd(rom_loader_pkg::REG_STATUS, 32'h0000_0005, 32'h0000_0005);
    wait_lb(1'b0);
    rd(rom_loader_pkg::REG_STATUS, 32'h0000_0008, 32'h0000_001A);
    wait_st(32'h0000_0013, 32'h0000_0010);
    rd(rom_loader_pkg::REG_STATUS, 32'h0000_001C);
    chk_img(1'b1);
    chk_irq(1'b1);
    rd(rom_loader_pkg::REG_IRQ_STAT, 32'h0000_0003);
    rd(rom_loader_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk_irq(1'b0);
    ce <= 1'b0;
    wr(ia(1), {24'h00_0000, ~rom(8'h01)});
    ce <= 1'b1;
    rd(ia(1), {24'h00_0000, rom(8'h01)});
    w = 8'($urandom);
    wr(ia(0), {24'h00_0000, w});
    wr(ia(15), 32'h0000_00FF);
    wr(8'hFC, 32'h0000_00FF);
    rd(ia(0), {24'h00_0000, w});
    rd(ia(15), 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    wr(rom_loader_pkg::REG_CONTROL, 32'h0000_0001);
    port_rd(rom(8'h06));
    port_rd(rom(8'h06) + 8'h01);
    chk_irq(1'b0);
    wr(ia(6), 32'h0000_0000);
    wr(rom_loader_pkg::REG_CONTROL, 32'h0000_0001);
    port_rd(8'h00);
    i_eeprom_model.mem[32] = 8'hFF;
    do_reset(1'b0, 1'b0);
    wait_lb(1'b1);
    wait_lb(1'b0);
    wait_st(32'h0000_0013, 32'h0000_0010);
    chk_img(1'b0);
    rd(rom_loader_pkg::REG_STATUS, 32'h0000_001C);
    do_reset(1'b0, 1'b1);
    wr(rom_loader_pkg::REG_IRQ_MASK, 32'h0000_0004);
    wait_lb(1'b1);
    wait_lb(1'b0);
    wait_st(32'h0000_0003, 32'h0000_0002);
    chk_irq(1'b1);
    rd(rom_loader_pkg::REG_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    test_done();
  end
endmodule
bind serial_rom_register_preloader rom_loader_props #(
  .QUARTER_CYC(QUARTER_CYC)
) i_rom_loader_props (
  .clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .loader_busy(loader_busy),
  .rom_strap_n(rom_strap_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
